// File: rtl/wor_option_regs.sv
// Write-once option registers on a classic Wishbone slave, with option decode
`timescale 1ns/10ps
`include "wor_params.svh"

// Summary of operation
// - Each option register takes one write after every reset, later writes ignored; the voltage-mode bit takes one only after power-on reset.
// - Reset clears every option bit except the detector voltage-mode bit.
// - Registers sit at two consecutive indices and read back at any time.
// - Voltage-mode bit cleared and unlocked only by power-on reset.
// - Clock enable and crystal enable choose oscillator pin use.
// - Crystal enable picks long or short clock monitor stabilization divider.
// - Crystal enable picks crystal or wide external clock monitor range.
// - Slow-crystal bit picks slow or fast range, only with clock enable.
// - Oscillator-in-stop clear stops both generated clocks in stop mode.
// - Watchdog rate bit picks long or short watchdog timeout.
// - Detector-in-stop keeps detector running in stop when power enabled.
// - Detector reset-disable blocks resets requested by the detector.
// - Detector power-disable removes power from the detector.
// - Voltage-mode bit picks higher or lower detector voltage mode.
// - Short-recovery bit picks short or long stop exit delay.
// - Stop exit by detector reset always uses the long delay.
// - STOP-enable clear makes the STOP instruction an illegal opcode.
// - Watchdog-disable bit disables the watchdog module.

module wor_option_regs (
  input  wire logic                   clk_in,
  input  wire logic                   resetn_in,
  input  wire logic                   por_resetn_in,
  input  wire wor_pkg::wor_wb_req_t   wb_req_in,
  output      wor_pkg::wor_wb_rsp_t   wb_rsp_out,
  output      wor_pkg::wor_opt1_t     opt1_out,
  output      wor_pkg::wor_opt2_t     opt2_out,
  output      logic                   osc1_is_clock_out,
  output      logic                   osc2_is_crystal_out,
  output      logic [12:0]            stab_div_count_out,
  output      wor_pkg::wor_mon_range_t monitor_range_out,
  input  wire logic                   stop_mode_in,
  output      logic                   gen_clocks_run_out,
  output      logic [17:0]            watchdog_timeout_out,
  output      logic                   watchdog_enable_out,
  output      logic                   detector_power_on_out,
  output      logic                   detector_run_in_stop_out,
  output      logic                   detector_high_voltage_out,
  input  wire logic                   detector_reset_req_in,
  output      logic                   detector_reset_out,
  input  wire logic                   stop_exit_by_detector_in,
  output      logic [12:0]            stop_recovery_count_out,
  input  wire logic                   stop_exec_in,
  output      logic                   stop_grant_out,
  output      logic                   illegal_opcode_out
);

  // Register select: each option register owns one byte address
  function automatic logic wor_hit(input logic [7:0] adr, input logic [7:0] loc);
    wor_hit = (adr == loc);
  endfunction

  // Next value of a write-once register: only the first write since reset lands
  function automatic logic [7:0] wor_once(input logic       wr,
                                          input logic       locked,
                                          input logic [7:0] cur,
                                          input logic [7:0] wdat);
    wor_once = (wr && !locked) ? wdat : cur;
  endfunction

  // Any reset, power-on included, clears the ordinary option state
  logic rst_any_n;
  assign rst_any_n = resetn_in & por_resetn_in;

  logic [7:0]  opt1_r;
  logic [7:0]  opt2_r;
  logic        vmode_r;
  logic        lock1_r;
  logic        lock2_r;
  logic        vlock_r;
  logic        ack_r;
  logic [31:0] rdat_r;

  logic        req;
  logic        hit1;
  logic        hit2;
  logic        wr1;
  logic        wr2;
  logic [7:0]  opt1_view;

  // Single-cycle registered ack, dropped the cycle after it was given
  assign req  = wb_req_in.cyc & wb_req_in.stb & ~ack_r;
  assign hit1 = wor_hit(wb_req_in.adr, `WOR_IDX_OPT1);
  assign hit2 = wor_hit(wb_req_in.adr, `WOR_IDX_OPT2);

  // Only a write that carries lane 0 counts as the one write
  assign wr1 = req & wb_req_in.we & wb_req_in.sel[0] & hit1;
  assign wr2 = req & wb_req_in.we & wb_req_in.sel[0] & hit2;

  always_comb begin
    opt1_view                 = opt1_r;
    opt1_view[`WOR_OPT1_VMODE] = vmode_r;
  end

  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // Read data follows the stored values whether written or not
  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      rdat_r <= 32'h00000000;
    end else if (req && !wb_req_in.we) begin
      if (hit1) begin
        rdat_r <= {24'h000000, opt1_view};
      end else if (hit2) begin
        rdat_r <= {24'h000000, opt2_r};
      end else begin
        rdat_r <= 32'h00000000;
      end
    end
  end

  assign wb_rsp_out.ack = ack_r;
  assign wb_rsp_out.dat = rdat_r;

  // Next values of the write-once registers and their locks
  logic [7:0]  opt1_nxt;
  logic [7:0]  opt2_nxt;
  logic        lock1_nxt;
  logic        lock2_nxt;
  logic        vmode_nxt;
  logic        vlock_nxt;

  // Voltage-mode bit is masked out here and kept in its own flop
  always_comb begin
    opt1_nxt = wor_once(wr1, lock1_r, opt1_r, wb_req_in.dat[7:0] & `WOR_OPT1_NOVMODE);
  end

  always_comb begin
    lock1_nxt = lock1_r | wr1;
  end

  always_comb begin
    opt2_nxt = wor_once(wr2, lock2_r, opt2_r, wb_req_in.dat[7:0] & `WOR_OPT2_MASK);
  end

  always_comb begin
    lock2_nxt = lock2_r | wr2;
  end

  // Voltage-mode bit locks on its first write after power-on only
  always_comb begin
    vmode_nxt = vmode_r;
    if (wr1 && !vlock_r) begin
      vmode_nxt = wb_req_in.dat[`WOR_OPT1_VMODE];
    end
  end

  always_comb begin
    vlock_nxt = vlock_r | wr1;
  end

  // Option register one, voltage-mode bit kept apart
  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      opt1_r <= `WOR_OPT1_RST;
    end else begin
      opt1_r <= opt1_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      lock1_r <= 1'b0;
    end else begin
      lock1_r <= lock1_nxt;
    end
  end

  // Option register two
  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      opt2_r <= `WOR_OPT2_RST;
    end else begin
      opt2_r <= opt2_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      lock2_r <= 1'b0;
    end else begin
      lock2_r <= lock2_nxt;
    end
  end

  // Voltage mode and its lock survive every reset but power-on
  always_ff @(posedge clk_in or negedge por_resetn_in) begin
    if (!por_resetn_in) begin
      vmode_r <= 1'b0;
    end else begin
      vmode_r <= vmode_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge por_resetn_in) begin
    if (!por_resetn_in) begin
      vlock_r <= 1'b0;
    end else begin
      vlock_r <= vlock_nxt;
    end
  end

  wor_pkg::wor_opt1_t o1;
  wor_pkg::wor_opt2_t o2;
  assign o1 = wor_pkg::wor_opt1_t'(opt1_view);
  assign o2 = wor_pkg::wor_opt2_t'(opt2_r);

  assign opt1_out = o1;
  assign opt2_out = o2;

  // Derived option levels, each one flop behind the option bits
  logic                    osc1_clk_r;
  logic                    osc2_xtal_r;
  logic [12:0]             stab_div_r;
  wor_pkg::wor_mon_range_t mon_range_r;
  logic                    clocks_run_r;
  logic [17:0]             wd_timeout_r;
  logic                    wd_enable_r;
  logic                    det_power_r;
  logic                    det_stop_run_r;
  logic                    det_reset_r;
  logic                    det_high_v_r;
  logic [12:0]             stop_rec_r;
  logic                    stop_grant_r;
  logic                    stop_illegal_r;

  // Oscillator pin use
  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      osc1_clk_r <= 1'b0;
    end else begin
      osc1_clk_r <= o2.external_clock_enable;
    end
  end

  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      osc2_xtal_r <= 1'b0;
    end else begin
      osc2_xtal_r <= o2.external_clock_enable & o2.crystal_enable;
    end
  end

  // Clock monitor stabilization divider and expected range
  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      stab_div_r <= `WOR_STAB_SHORT;
    end else begin
      stab_div_r <= o2.crystal_enable ? `WOR_STAB_LONG : `WOR_STAB_SHORT;
    end
  end

  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      mon_range_r <= wor_pkg::WOR_MON_WIDE_EXT;
    end else if (!o2.crystal_enable) begin
      mon_range_r <= wor_pkg::WOR_MON_WIDE_EXT;
    end else if (o2.slow_crystal_select && o2.external_clock_enable) begin
      mon_range_r <= wor_pkg::WOR_MON_CRYSTAL_SLOW;
    end else begin
      mon_range_r <= wor_pkg::WOR_MON_CRYSTAL_FAST;
    end
  end

  // Generated clocks held off in stop unless the oscillator is kept on
  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      clocks_run_r <= 1'b1;
    end else begin
      clocks_run_r <= ~stop_mode_in | o2.oscillator_in_stop;
    end
  end

  // Watchdog timeout and enable
  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      wd_timeout_r <= `WOR_WD_SHORT;
    end else begin
      wd_timeout_r <= o1.watchdog_rate_select ? `WOR_WD_LONG : `WOR_WD_SHORT;
    end
  end

  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      wd_enable_r <= 1'b1;
    end else begin
      wd_enable_r <= ~o1.watchdog_disable;
    end
  end

  // Low-voltage detector power, stop behaviour and reset gating
  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      det_power_r <= 1'b1;
    end else begin
      det_power_r <= ~o1.detector_power_disable;
    end
  end

  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      det_stop_run_r <= 1'b0;
    end else begin
      det_stop_run_r <= ~o1.detector_power_disable & o1.detector_in_stop;
    end
  end

  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      det_reset_r <= 1'b0;
    end else begin
      det_reset_r <= detector_reset_req_in & ~o1.detector_reset_disable;
    end
  end

  // Voltage mode flop only sees power-on reset, so its follower does too
  always_ff @(posedge clk_in or negedge por_resetn_in) begin
    if (!por_resetn_in) begin
      det_high_v_r <= 1'b0;
    end else begin
      det_high_v_r <= vmode_r;
    end
  end

  // Stop recovery delay; short delay needs the oscillator kept on or an
  // external source, which is left to software
  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      stop_rec_r <= `WOR_REC_LONG;
    end else if (o1.short_recovery && !stop_exit_by_detector_in) begin
      stop_rec_r <= `WOR_REC_SHORT;
    end else begin
      stop_rec_r <= `WOR_REC_LONG;
    end
  end

  // STOP instruction: granted or turned into an illegal opcode
  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      stop_grant_r <= 1'b0;
    end else begin
      stop_grant_r <= stop_exec_in & o1.stop_enable;
    end
  end

  always_ff @(posedge clk_in or negedge rst_any_n) begin
    if (!rst_any_n) begin
      stop_illegal_r <= 1'b0;
    end else begin
      stop_illegal_r <= stop_exec_in & ~o1.stop_enable;
    end
  end

  // Levels to the clock generator, watchdog, detector and stop logic
  assign osc1_is_clock_out         = osc1_clk_r;
  assign osc2_is_crystal_out       = osc2_xtal_r;
  assign stab_div_count_out        = stab_div_r;
  assign monitor_range_out         = mon_range_r;
  assign gen_clocks_run_out        = clocks_run_r;
  assign watchdog_timeout_out      = wd_timeout_r;
  assign watchdog_enable_out       = wd_enable_r;
  assign detector_power_on_out     = det_power_r;
  assign detector_run_in_stop_out  = det_stop_run_r;
  assign detector_reset_out        = det_reset_r;
  assign detector_high_voltage_out = det_high_v_r;
  assign stop_recovery_count_out   = stop_rec_r;
  assign stop_grant_out            = stop_grant_r;
  assign illegal_opcode_out        = stop_illegal_r;

endmodule // wor_option_regs

// File: rtl/wor_params.svh
// Offsets, field positions, reset values and counts for the option registers
`ifndef WOR_PARAMS_SVH
`define WOR_PARAMS_SVH

`define WOR_ADDR_W        8
`define WOR_IDX_OPT1      8'h1E
`define WOR_IDX_OPT2      8'h1F

`define WOR_OPT1_RST      8'h00
`define WOR_OPT2_RST      8'h00
`define WOR_OPT2_MASK     8'h0F
`define WOR_OPT1_VMODE    3
`define WOR_OPT1_NOVMODE  8'hF7

`define WOR_STAB_LONG     13'h1000
`define WOR_STAB_SHORT    13'h0010
`define WOR_REC_SHORT     13'h0020
`define WOR_REC_LONG      13'h1000
`define WOR_WD_LONG       18'h3FFF0
`define WOR_WD_SHORT      18'h01FF0

`endif

// File: rtl/wor_pkg.sv
// Types shared by the write-once option register block
package wor_pkg;

  typedef struct packed {
    logic watchdog_rate_select;
    logic detector_in_stop;
    logic detector_reset_disable;
    logic detector_power_disable;
    logic detector_voltage_mode;
    logic short_recovery;
    logic stop_enable;
    logic watchdog_disable;
  } wor_opt1_t;

  typedef struct packed {
    logic [3:0] reserved;
    logic       crystal_enable;
    logic       slow_crystal_select;
    logic       external_clock_enable;
    logic       oscillator_in_stop;
  } wor_opt2_t;

  typedef enum logic [1:0] {
    WOR_MON_WIDE_EXT     = 2'h0,
    WOR_MON_CRYSTAL_FAST = 2'h1,
    WOR_MON_CRYSTAL_SLOW = 2'h2
  } wor_mon_range_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wor_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wor_wb_rsp_t;

endpackage

// File: tb/wor_option_regs_sva.sv
// Checker for the write-once option register block
`timescale 1ns/10ps
module wor_option_regs_sva (
  input wire logic                 clk_in,
  input wire logic                 resetn_in,
  input wire logic                 por_resetn_in,
  input wire wor_pkg::wor_wb_req_t wb_req_in,
  input wire wor_pkg::wor_wb_rsp_t wb_rsp_out,
  input wire wor_pkg::wor_opt1_t   opt1_out,
  input wire wor_pkg::wor_opt2_t   opt2_out,
  input wire logic                 osc2_is_crystal_out,
  input wire logic [12:0]          stab_div_count_out,
  input wire logic                 stop_mode_in,
  input wire logic                 gen_clocks_run_out,
  input wire logic [17:0]          watchdog_timeout_out,
  input wire logic                 detector_reset_req_in,
  input wire logic                 detector_reset_out,
  input wire logic                 stop_exit_by_detector_in,
  input wire logic [12:0]          stop_recovery_count_out,
  input wire logic                 stop_exec_in,
  input wire logic                 stop_grant_out,
  input wire logic                 illegal_opcode_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in || !por_resetn_in);

  property p_ack;
    wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack |=> wb_rsp_out.ack ##1 !wb_rsp_out.ack;
  endproperty
  property p_chg;
    !$stable(opt1_out) || !$stable(opt2_out) |-> wb_rsp_out.ack;
  endproperty
  property p_pins;
    1'b1 |=> osc2_is_crystal_out == $past(opt2_out.external_clock_enable & opt2_out.crystal_enable);
  endproperty
  property p_stab;
    1'b1 |=> stab_div_count_out == ($past(opt2_out.crystal_enable) ? 13'h1000 : 13'h0010);
  endproperty
  property p_clk;
    stop_mode_in && !opt2_out.oscillator_in_stop |=> !gen_clocks_run_out;
  endproperty
  property p_wdt;
    1'b1 |=> watchdog_timeout_out == ($past(opt1_out.watchdog_rate_select) ? 18'h3FFF0 : 18'h01FF0);
  endproperty
  property p_det;
    1'b1 |=> detector_reset_out == $past(detector_reset_req_in & !opt1_out.detector_reset_disable);
  endproperty
  property p_rec;
    opt1_out.short_recovery && !stop_exit_by_detector_in |=> stop_recovery_count_out == 13'h0020;
  endproperty
  property p_rec_long;
    stop_exit_by_detector_in |=> stop_recovery_count_out == 13'h1000;
  endproperty
  property p_stop;
    stop_exec_in |=> stop_grant_out == $past(opt1_out.stop_enable) && illegal_opcode_out != stop_grant_out;
  endproperty

  a_ack: assert property (p_ack) else $error("ack not a single cycle");
  a_chg: assert property (p_chg) else $error("option changed without write");
  a_pins: assert property (p_pins) else $error("pin use wrong");
  a_stab: assert property (p_stab) else $error("stabilization count wrong");
  a_clk: assert property (p_clk) else $error("clocks run in stop");
  a_wdt: assert property (p_wdt) else $error("watchdog timeout wrong");
  a_det: assert property (p_det) else $error("detector reset gating wrong");
  a_rec: assert property (p_rec) else $error("short recovery wrong");
  a_rec_long: assert property (p_rec_long) else $error("long recovery wrong");
  a_stop: assert property (p_stop) else $error("stop decode wrong");

  c_write: cover property (wb_req_in.we && wb_rsp_out.ack);
  c_illegal: cover property (illegal_opcode_out);
  c_short: cover property (stop_recovery_count_out == 13'h0020);
endmodule // wor_option_regs_sva

bind wor_option_regs wor_option_regs_sva u_sva (.clk_in, .resetn_in, .por_resetn_in, .wb_req_in,
  .wb_rsp_out, .opt1_out, .opt2_out, .osc2_is_crystal_out, .stab_div_count_out, .stop_mode_in,
  .gen_clocks_run_out, .watchdog_timeout_out, .detector_reset_req_in, .detector_reset_out,
  .stop_exit_by_detector_in, .stop_recovery_count_out, .stop_exec_in, .stop_grant_out,
  .illegal_opcode_out);

// File: tb/wor_option_regs_tb.sv
// Testbench for the write-once option register block
`timescale 1ns/10ps
module wor_option_regs_tb;
  logic                    clk_in = 1'b0;
  logic                    resetn_in = 1'b0;
  logic                    por_resetn_in = 1'b0;
  logic                    stop_mode_in = 1'b0;
  logic                    detector_reset_req_in = 1'b0;
  logic                    stop_exit_by_detector_in = 1'b0;
  logic                    stop_exec_in = 1'b0;
  wor_pkg::wor_wb_req_t    wb_req_in = '0;
  wor_pkg::wor_wb_rsp_t    wb_rsp_out;
  wor_pkg::wor_opt1_t      opt1_out;
  wor_pkg::wor_opt2_t      opt2_out;
  wor_pkg::wor_mon_range_t monitor_range_out;
  logic [12:0]             stab_div_count_out, stop_recovery_count_out;
  logic [17:0]             watchdog_timeout_out;
  logic                    osc1_is_clock_out, osc2_is_crystal_out, gen_clocks_run_out;
  logic                    watchdog_enable_out, detector_power_on_out, detector_run_in_stop_out;
  logic                    detector_high_voltage_out, detector_reset_out;
  logic                    stop_grant_out, illegal_opcode_out;
  int                      err_count = 0;
  int                      n_compared = 0;

  always #5 clk_in = ~clk_in;

  wor_option_regs dut (.clk_in, .resetn_in, .por_resetn_in, .wb_req_in, .wb_rsp_out, .opt1_out,
    .opt2_out, .osc1_is_clock_out, .osc2_is_crystal_out, .stab_div_count_out, .monitor_range_out,
    .stop_mode_in, .gen_clocks_run_out, .watchdog_timeout_out, .watchdog_enable_out,
    .detector_power_on_out, .detector_run_in_stop_out, .detector_high_voltage_out,
    .detector_reset_req_in, .detector_reset_out, .stop_exit_by_detector_in,
    .stop_recovery_count_out, .stop_exec_in, .stop_grant_out, .illegal_opcode_out);

  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Classic cycle: hold until ack is sampled, then release for one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    wb_req_in <= '{1'b1, 1'b1, w, 4'h1, a, {24'h0, d}};
    do begin
      @(posedge clk_in);
    end while (wb_rsp_out.ack !== 1'b1);
    q = wb_rsp_out.dat;
    wb_req_in <= '0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, {24'h0, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic pulse_rst(input logic por);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    por_resetn_in <= !por;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    por_resetn_in <= 1'b1;
    @(posedge clk_in);
  endtask

  initial begin
    repeat (3000) @(posedge clk_in);
    err_count++;
    stop_test;
  end

  initial begin
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    por_resetn_in <= 1'b1;
    @(posedge clk_in);
    chk(stab_div_count_out, 13'h0010);
    chk(watchdog_timeout_out, 18'h01FF0);
    rd(8'h1E, 8'h00);
    rd(8'h1F, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h1F, 8'h0E);
    wr(8'h1F, 8'h01);
    rd(8'h1F, 8'h0E);
    chk(opt2_out, 8'h0E);
    chk(osc1_is_clock_out, 1'b1);
    chk(osc2_is_crystal_out, 1'b1);
    chk(stab_div_count_out, 13'h1000);
    chk(monitor_range_out, wor_pkg::WOR_MON_CRYSTAL_SLOW);
    wr(8'h1E, 8'h5A);
    wr(8'h1E, 8'hFF);
    rd(8'h1E, 8'h5A);
    chk(opt1_out, 8'h5A);
    chk(detector_power_on_out, 1'b0);
    chk(detector_run_in_stop_out, 1'b0);
    chk(detector_high_voltage_out, 1'b1);
    chk(watchdog_enable_out, 1'b1);
    detector_reset_req_in <= 1'b1;
    stop_exec_in <= 1'b1;
    @(posedge clk_in);
    stop_exec_in <= 1'b0;
    #1;
    chk(stop_grant_out, 1'b1);
    chk(detector_reset_out, 1'b1);
    pulse_rst(1'b0);
    rd(8'h1E, 8'h08);
    rd(8'h1F, 8'h00);
    // Square-wave external clock: short recovery allowed with the oscillator off in stop
    wr(8'h1F, 8'h02);
    chk(opt2_out, 8'h02);
    wr(8'h1E, 8'hE5);
    rd(8'h1E, 8'hED);
    chk(watchdog_timeout_out, 18'h3FFF0);
    chk(watchdog_enable_out, 1'b0);
    chk(detector_run_in_stop_out, 1'b1);
    chk(stop_recovery_count_out, 13'h0020);
    chk(monitor_range_out, wor_pkg::WOR_MON_WIDE_EXT);
    stop_exit_by_detector_in <= 1'b1;
    stop_mode_in <= 1'b1;
    stop_exec_in <= 1'b1;
    @(posedge clk_in);
    stop_exec_in <= 1'b0;
    #1;
    chk(illegal_opcode_out, 1'b1);
    @(posedge clk_in);
    #1;
    chk(detector_reset_out, 1'b0);
    chk(stop_recovery_count_out, 13'h1000);
    chk(gen_clocks_run_out, 1'b0);
    @(posedge clk_in);
    pulse_rst(1'b1);
    rd(8'h1E, 8'h00);
    wr(8'h1F, 8'h0D);
    chk(osc2_is_crystal_out, 1'b0);
    chk(monitor_range_out, wor_pkg::WOR_MON_CRYSTAL_FAST);
    chk(gen_clocks_run_out, 1'b1);
    stop_test;
  end
endmodule // wor_option_regs_tb
